// File: spc_pkg.sv
// shared types and constants for spindle positioning control
// assumes positions, distances and times come from the parameter store
package spc_pkg;
  typedef logic signed [23:0] pos_t;
  typedef logic signed [24:0] dist_t;

  // status word object and field positions
  localparam logic [15:0] STATUS_INDEX = 16'h204e;
  localparam logic [7:0] STATUS_SUB = 8'h01;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam int ST_MOVING = 0;
  localparam int ST_SPEED_LO = 8;
  localparam int ST_DIR_LO = 10;
  localparam int ST_ARROWS = 12;
  localparam int ST_IN_POS = 15;
  localparam logic APPROACH_UP = 1'b0;

  // millisecond time base at a 50 ns clock
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SPD_STOP = 2'h0,
    SPD_CRAWL = 2'h1,
    SPD_CREEP = 2'h2,
    SPD_FAST = 2'h3
  } speed_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_OPEN = 3'h1,
    S_DRIVE = 3'h3,
    S_DWELL = 3'h2,
    S_CLOSE = 3'h7
  } pos_state_t;

  typedef struct packed {
    logic approach_dir;
    pos_t loop_len;
    pos_t tolerance;
    pos_t creep_dist;
    pos_t crawl_dist;
    pos_t switch_off;
    logic [15:0] loop_ms;
    logic [15:0] clamp_ms;
  } pos_cfg_t;

  function automatic dist_t ext(input pos_t p);
    return {p[23], p};
  endfunction
endpackage

// File: tick_divider.sv
// one-cycle enable pulse every CYCLES clocks
// assumes a single free-running clock
`timescale 1ns/1ps
module tick_divider #(
  parameter int unsigned CYCLES = spc_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  output logic tick
);
  logic [20:0] cnt_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 21'h0_0000;
      tick <= 1'b0;
    end else if (cnt_q == 21'(CYCLES - 1)) begin
      cnt_q <= 21'h0_0000;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 21'h0_0001;
      tick <= 1'b0;
    end
  end
endmodule

// File: approach_zone.sv
// remaining distance to the current goal and the speed level it calls for
// purely combinational; the caller registers the results
`timescale 1ns/1ps
module approach_zone (
  input wire spc_pkg::dist_t pos,
  input wire spc_pkg::dist_t goal,
  input wire logic up,
  input wire logic use_off,
  input wire spc_pkg::pos_t creep_dist,
  input wire spc_pkg::pos_t crawl_dist,
  input wire spc_pkg::pos_t switch_off,
  output spc_pkg::dist_t rem,
  output logic arrive,
  output spc_pkg::speed_t speed
);
  import spc_pkg::*;
  dist_t off;

  always_comb begin
    rem = up ? dist_t'(goal - pos) : dist_t'(pos - goal);
    // switch-off offset only on the leg that ends at the target
    off = use_off ? ext(switch_off) : dist_t'(0);
    // negative remainder means overshoot, stop as well
    arrive = (rem <= off);
    if (arrive) begin
      speed = SPD_STOP;
    end else if (rem <= ext(crawl_dist)) begin
      speed = SPD_CRAWL;
    end else if (rem <= ext(creep_dist)) begin
      speed = SPD_CREEP;
    end else begin
      speed = SPD_FAST;
    end
  end
endmodule

// File: spindle_positioning_control.sv
// motor positioning of a spindle position display with loop drive and clamping
// assumes position, set value and parameters arrive on mclk from the bus logic
// Notes on behaviour
// - with play compensation the target is always reached from one side.
// - approach setting zero means final approach runs in increasing position.
// - zero loop length drives straight to target, ignoring side and dwell.
// - motor stands still at the reversal point for the loop dwell time.
// - fast drops to creep when remaining distance reaches creep threshold.
// - drops to crawl when remaining distance reaches crawl threshold.
// - motor stops early by the switch-off value; zero stops on target.
// - in-position when actual lies within tolerance of set value.
// - status bits 8 to 9 mirror the two speed level outputs.
// - status bits 10 to 11 mirror the two direction outputs.
// - status bit 12 set while direction arrows are shown.
// - status word sent in both transmit objects and readable on demand.
// - clamp time delays motor start after release and re-clamp after stop.
// - with clamp time, moving covers both clamp delay periods.
// - in manual mode arrows show the rotation needed toward target.
`timescale 1ns/1ps
module spindle_positioning_control #(
  parameter int unsigned TICK_CYCLES = spc_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire spc_pkg::pos_cfg_t cfg,
  input wire spc_pkg::pos_t set_value,
  input wire spc_pkg::pos_t actual_pos,
  input wire logic motor_enable,
  input wire logic start,
  input wire logic rd_req,
  input wire logic [15:0] rd_index,
  input wire logic [7:0] rd_sub,
  input wire logic pdo_sync,
  output logic direction_output_a,
  output logic direction_output_b,
  output logic speed_level_output_a,
  output logic speed_level_output_b,
  output logic clamp_release,
  output logic arrow_up,
  output logic arrow_down,
  output logic in_position,
  output logic [15:0] status_q,
  output logic rd_ack,
  output logic rd_err,
  output logic [15:0] rd_data,
  output logic [1:0] tpdo_strobe,
  output logic [15:0] tpdo_data
);
  import spc_pkg::*;

  pos_state_t state_q;
  dist_t goal_q;
  logic up_q;
  logic final_q;
  logic loop_used_q;
  logic clamp_used_q;
  logic [16:0] timer_q;
  logic [16:0] clamp_load;
  logic [16:0] loop_load;
  logic tick;
  dist_t rem;
  logic arrive;
  speed_t zone_speed;
  dist_t pos_x;
  dist_t set_x;
  dist_t err;
  logic up_needed;
  logic loop_needed;
  logic go;
  logic moving_d;
  logic dir_a_d;
  logic dir_b_d;
  speed_t spd_d;
  logic in_pos_d;
  logic arr_up_d;
  logic arr_dn_d;
  logic [15:0] status_d;
  logic rd_hit;

  tick_divider #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .mclk(mclk),
    .rst_b(rst_b),
    .tick(tick)
  );

  approach_zone u_zone (
    .pos(pos_x),
    .goal(goal_q),
    .up(up_q),
    .use_off(final_q),
    .creep_dist(cfg.creep_dist),
    .crawl_dist(cfg.crawl_dist),
    .switch_off(cfg.switch_off),
    .rem(rem),
    .arrive(arrive),
    .speed(zone_speed)
  );

  always_comb begin
    pos_x = ext(actual_pos);
    set_x = ext(set_value);
    err = dist_t'(set_x - pos_x);
    up_needed = (set_x > pos_x);
    go = start && motor_enable && (state_q == S_IDLE);
    // one tick more than asked: the first tick may come a single cycle after entry
    clamp_load = (cfg.clamp_ms == 16'h0000) ? 17'h0_0000
                                            : {1'b0, cfg.clamp_ms} + 17'h0_0001;
    loop_load = (cfg.loop_ms == 16'h0000) ? 17'h0_0000
                                          : {1'b0, cfg.loop_ms} + 17'h0_0001;
    // a loop is needed only when the direct path runs against the approach side
    loop_needed = (cfg.loop_len != '0) && (set_x != pos_x) &&
                  (up_needed != (cfg.approach_dir == APPROACH_UP));
  end

  // sequencing of clamp, drive legs and loop dwell
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      goal_q <= '0;
      up_q <= 1'b0;
      final_q <= 1'b0;
      loop_used_q <= 1'b0;
      clamp_used_q <= 1'b0;
      timer_q <= 17'h0_0000;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (go) begin
            loop_used_q <= loop_needed;
            clamp_used_q <= (cfg.clamp_ms != 16'h0000);
            timer_q <= clamp_load;
            if (loop_needed) begin
              // overshoot beyond target by the loop length first
              goal_q <= up_needed ? dist_t'(set_x + ext(cfg.loop_len))
                                  : dist_t'(set_x - ext(cfg.loop_len));
              up_q <= up_needed;
              final_q <= 1'b0;
            end else begin
              goal_q <= set_x;
              up_q <= up_needed;
              final_q <= 1'b1;
            end
            state_q <= (cfg.clamp_ms != 16'h0000) ? S_OPEN : S_DRIVE;
          end
        end
        S_OPEN: begin
          if (timer_q == 17'h0_0000) begin
            state_q <= S_DRIVE;
          end else if (tick) begin
            timer_q <= timer_q - 17'h0_0001;
          end
        end
        S_DRIVE: begin
          if (arrive) begin
            if (!final_q) begin
              state_q <= S_DWELL;
              timer_q <= loop_load;
            end else if (clamp_used_q) begin
              state_q <= S_CLOSE;
              timer_q <= clamp_load;
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        S_DWELL: begin
          if (timer_q == 17'h0_0000) begin
            // reverse and come back onto the target from the set side
            goal_q <= set_x;
            up_q <= (cfg.approach_dir == APPROACH_UP);
            final_q <= 1'b1;
            state_q <= S_DRIVE;
          end else if (tick) begin
            timer_q <= timer_q - 17'h0_0001;
          end
        end
        S_CLOSE: begin
          if (timer_q == 17'h0_0000) begin
            state_q <= S_IDLE;
          end else if (tick) begin
            timer_q <= timer_q - 17'h0_0001;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    moving_d = (state_q != S_IDLE);
    // motor runs only in the drive state; dwell and clamp phases hold it
    dir_a_d = (state_q == S_DRIVE) && !arrive && up_q;
    dir_b_d = (state_q == S_DRIVE) && !arrive && !up_q;
    spd_d = (state_q == S_DRIVE) ? zone_speed : SPD_STOP;
    in_pos_d = (err <= ext(cfg.tolerance)) && (-err <= ext(cfg.tolerance));
    // arrows only guide a hand-turned spindle
    arr_up_d = !motor_enable && !in_pos_d && (err > dist_t'(0));
    arr_dn_d = !motor_enable && !in_pos_d && (err < dist_t'(0));
    status_d = STATUS_RESET;
    status_d[ST_MOVING] = moving_d;
    status_d[ST_SPEED_LO +: 2] = spd_d;
    status_d[ST_DIR_LO +: 2] = {dir_b_d, dir_a_d};
    status_d[ST_ARROWS] = arr_up_d || arr_dn_d;
    status_d[ST_IN_POS] = in_pos_d;
    rd_hit = (rd_index == STATUS_INDEX) && (rd_sub == STATUS_SUB);
  end

  // pins and status word change together so the mirror is exact
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      direction_output_a <= 1'b0;
      direction_output_b <= 1'b0;
      speed_level_output_a <= 1'b0;
      speed_level_output_b <= 1'b0;
      arrow_up <= 1'b0;
      arrow_down <= 1'b0;
      in_position <= 1'b0;
      status_q <= STATUS_RESET;
    end else begin
      direction_output_a <= dir_a_d;
      direction_output_b <= dir_b_d;
      speed_level_output_a <= spd_d[0];
      speed_level_output_b <= spd_d[1];
      arrow_up <= arr_up_d;
      arrow_down <= arr_dn_d;
      in_position <= in_pos_d;
      status_q <= status_d;
    end
  end

  // clamp stays open from before motion until the close delay has run out
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clamp_release <= 1'b0;
    end else begin
      clamp_release <= clamp_used_q && (state_q != S_IDLE);
    end
  end

  // on-demand read and cyclic transmit of the status word
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ack <= 1'b0;
      rd_err <= 1'b0;
      rd_data <= 16'h0000;
      tpdo_strobe <= 2'h0;
      tpdo_data <= 16'h0000;
    end else begin
      rd_ack <= rd_req;
      rd_err <= rd_req && !rd_hit;
      rd_data <= (rd_req && rd_hit) ? status_q : 16'h0000;
      tpdo_strobe <= pdo_sync ? 2'h3 : 2'h0;
      if (pdo_sync) begin
        tpdo_data <= status_q;
      end
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_final_side: assert property ((state_q == S_DRIVE) && final_q && loop_used_q
      |-> up_q == (cfg.approach_dir == APPROACH_UP))
    else $error("final approach from wrong side");
  a_loop_overshoot: assert property (go && loop_needed && up_needed
      |=> !final_q && goal_q == $past(set_x) + $past(ext(cfg.loop_len)))
    else $error("loop goal not beyond target");
  a_direct_drive: assert property (go && (cfg.loop_len == '0)
      |=> final_q && goal_q == $past(set_x))
    else $error("zero loop did not drive direct");
  a_dwell_still: assert property (state_q == S_DWELL
      |=> !direction_output_a && !direction_output_b)
    else $error("motor moved during dwell");
  a_creep_zone: assert property ((state_q == S_DRIVE) && !arrive &&
      rem > ext(cfg.crawl_dist) && rem <= ext(cfg.creep_dist)
      |=> status_q[9:8] == SPD_CREEP)
    else $error("creep speed missing");
  a_crawl_zone: assert property ((state_q == S_DRIVE) && !arrive &&
      rem <= ext(cfg.crawl_dist) |=> status_q[9:8] == SPD_CRAWL)
    else $error("crawl speed missing");
  a_switch_off: assert property ((state_q == S_DRIVE) && final_q &&
      rem <= ext(cfg.switch_off) |=> state_q != S_DRIVE ##1 status_q[9:8] == SPD_STOP)
    else $error("motor not stopped at switch-off point");
  a_in_window: assert property ((err <= ext(cfg.tolerance)) && (-err <= ext(cfg.tolerance))
      |=> status_q[ST_IN_POS] && in_position)
    else $error("in-position flag missing");
  a_moving_bit: assert property (status_q[ST_MOVING] == $past(state_q != S_IDLE))
    else $error("moving bit wrong");
  a_pin_mirror: assert property (status_q[11:8] == {direction_output_b,
      direction_output_a, speed_level_output_b, speed_level_output_a})
    else $error("status does not mirror pins");
  a_arrow_flag: assert property (status_q[ST_ARROWS] == (arrow_up || arrow_down))
    else $error("arrow flag mismatch");
  a_arrow_way: assert property (!motor_enable && !in_pos_d && (err > dist_t'(0))
      |=> arrow_up && !arrow_down)
    else $error("arrow does not point toward target");
  a_clamp_delay: assert property ((state_q == S_OPEN) && (timer_q != 17'h0_0000)
      |=> state_q != S_DRIVE && !direction_output_a && !direction_output_b)
    else $error("motor started before clamp delay");
  a_status_read: assert property (rd_req && rd_hit
      |=> rd_ack && !rd_err && rd_data == $past(status_q))
    else $error("status read wrong");

  c_loop_drive: cover property ((state_q == S_DWELL) ##[1:1000] (state_q == S_DRIVE));
  c_clamped_run: cover property ((state_q == S_OPEN) ##[1:1000] (state_q == S_CLOSE));
  c_direct_done: cover property (go && !loop_needed ##[1:1000] status_q[ST_IN_POS]);
endmodule

// File: spindle_motor.sv
// behavioural spindle drive: moves the shaft each clock by the commanded speed
// assumes the direction and speed level pins of the positioning block, one clock
`timescale 1ns/1ps
module spindle_motor (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic dir_up,
  input wire logic dir_down,
  input wire logic [1:0] spd,
  output spc_pkg::pos_t pos
);
  import spc_pkg::*;
  pos_t step;
  always_comb begin
    case (spd)
      2'h1: step = 24'h00_0001;
      2'h2: step = 24'h00_0002;
      2'h3: step = 24'h00_0004;
      default: step = 24'h00_0000;
    endcase
  end
  // both direction pins high stalls the shaft, as a real contactor pair would
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pos <= 24'h00_0000;
    end else if (dir_up && !dir_down) begin
      pos <= pos + step;
    end else if (dir_down && !dir_up) begin
      pos <= pos - step;
    end
  end
endmodule

// File: tb.sv
// self-checking bench for the spindle positioning block
// assumes the drive model closes the loop from motor pins to actual position
`timescale 1ns/1ps
module tb;
  import spc_pkg::*;
  typedef struct {int sv; int lp; logic dir; logic up; logic lps;} row_t;
  // direct up, loop from above, loop against side down, zero loop ignoring side
  row_t rows [4] = '{'{24'h00_00c8, 24'h00_001e, 1'b0, 1'b1, 1'b0},
                     '{24'h00_0064, 24'h00_001e, 1'b0, 1'b1, 1'b1},
                     '{24'h00_0096, 24'h00_001e, 1'b1, 1'b0, 1'b1},
                     '{24'h00_003c, 24'h00_0000, 1'b0, 1'b0, 1'b0}};
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  pos_cfg_t cfg;
  pos_t set_value, pos;
  logic motor_enable, start, rd_req, pdo_sync, last_up;
  logic [15:0] rd_index, status_q, rd_data, tpdo_data, exp_st;
  logic [7:0] rd_sub;
  logic da, db, sa, sb, clamp_release, arrow_up, arrow_down, in_position, rd_ack, rd_err;
  logic [1:0] tpdo_strobe;
  int n_fail = 0;
  int num_checks = 0;
  int stops, first_go, tail, gap, last_spd, creep;

  always #25 mclk = ~mclk;

  spindle_positioning_control #(.TICK_CYCLES(4)) dut (
    .mclk(mclk), .rst_b(rst_b), .cfg(cfg), .set_value(set_value), .actual_pos(pos),
    .motor_enable(motor_enable), .start(start), .rd_req(rd_req), .rd_index(rd_index),
    .rd_sub(rd_sub), .pdo_sync(pdo_sync), .direction_output_a(da), .direction_output_b(db),
    .speed_level_output_a(sa), .speed_level_output_b(sb), .clamp_release(clamp_release),
    .arrow_up(arrow_up), .arrow_down(arrow_down), .in_position(in_position),
    .status_q(status_q), .rd_ack(rd_ack), .rd_err(rd_err), .rd_data(rd_data),
    .tpdo_strobe(tpdo_strobe), .tpdo_data(tpdo_data));

  spindle_motor m0 (.mclk(mclk), .rst_b(rst_b), .dir_up(da), .dir_down(db),
    .spd({sb, sa}), .pos(pos));

  task automatic results;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step_clk;
    @(posedge mclk);
    #5;
  endtask

  function automatic logic near(input int a, input int b, input int t);
    return (a - b <= t) && (b - a <= t);
  endfunction

  // one positioning run, watching the pins every cycle until moving clears
  task automatic run_pos(input int sv);
    int n;
    logic [3:0] prev;
    set_value = pos_t'(sv);
    start = 1'b1;
    step_clk;
    start = 1'b0;
    step_clk;
    step_clk;
    chk("moving_set", status_q[ST_MOVING], 1'b1);
    n = 0;
    stops = 0;
    first_go = -1;
    tail = 0;
    gap = 0;
    creep = 0;
    last_spd = 0;
    prev = {db, da, sb, sa};
    while (status_q[ST_MOVING] === 1'b1 && n < 3000) begin
      if ({db, da, sb, sa} == prev) begin
        chk("st_speed", status_q[9:8], {sb, sa});
        chk("st_dir", status_q[11:10], {db, da});
      end
      gap += (clamp_release !== 1'b1);
      creep |= ({sb, sa} == 2'h2);
      if ({sb, sa} == 2'h0) begin
        stops++;
        tail++;
      end else begin
        last_spd = {sb, sa};
        last_up = da;
        tail = 0;
        first_go = (first_go < 0) ? n : first_go;
      end
      prev = {db, da, sb, sa};
      n++;
      step_clk;
    end
    if (n >= 3000) begin
      chk("timeout", 1'b0, 1'b1);
      results;
    end
    chk("in_pos", in_position, near(int'(set_value), int'(pos), 4));
    chk("st_in_pos", status_q[ST_IN_POS], near(int'(set_value), int'(pos), 4));
  endtask

  initial begin
    cfg = '0;
    // approach side first, then distances, then times
    cfg.approach_dir = APPROACH_UP;
    cfg.tolerance = 24'h00_0004;
    cfg.creep_dist = 24'h00_0014;
    cfg.crawl_dist = 24'h00_0008;
    cfg.loop_ms = 16'h0003;
    set_value = '0;
    motor_enable = 1'b1;
    start = 1'b0;
    rd_req = 1'b0;
    pdo_sync = 1'b0;
    rd_index = STATUS_INDEX;
    rd_sub = STATUS_SUB;
    repeat (3) @(posedge mclk);
    #5;
    chk("status_rst", status_q, STATUS_RESET);
    chk("pins_rst", {da, db, sa, sb}, 4'h0);
    rst_b = 1'b1;
    step_clk;
    // shaft and set value both start at zero, so only in-position shows
    chk("st_start", status_q, 16'h8000);
    for (int i = 0; i < 4; i++) begin
      cfg.loop_len = pos_t'(rows[i].lp);
      cfg.approach_dir = rows[i].dir;
      run_pos(rows[i].sv);
      chk("final_up", last_up, rows[i].up);
      // three 4-cycle dwell ticks plus the closing stop sample
      chk("dwell", stops >= 13, rows[i].lps);
      chk("creep_used", creep, 1);
      chk("crawl_last", last_spd, 2'h1);
    end
    // stop early by the switch-off distance on a direct run up to 120
    cfg.switch_off = 24'h00_000a;
    run_pos(24'h00_0078);
    chk("switch_off", int'(pos) >= 24'h00_006e && int'(pos) <= 24'h00_0071, 1'b1);
    cfg.switch_off = 24'h00_0000;
    cfg.clamp_ms = 16'h0002;
    run_pos(24'h00_00a0);
    chk("clamp_start", first_go >= 7, 1'b1);
    chk("clamp_stop", tail >= 8, 1'b1);
    chk("clamp_moving", gap, 0);
    chk("clamp_closed", clamp_release, 1'b0);
    cfg.clamp_ms = 16'h0000;
    // manual mode: arrows point toward the target, start is refused
    motor_enable = 1'b0;
    for (int k = 0; k < 3; k++) begin
      set_value = (k == 0) ? pos + 24'h00_0032 : (k == 1) ? pos - 24'h00_0032 : pos;
      start = (k == 0);
      repeat (3) step_clk;
      start = 1'b0;
      chk("arrow_up", arrow_up, k == 0);
      chk("arrow_dn", arrow_down, k == 1);
      chk("st_arrows", status_q[ST_ARROWS], k != 2);
      chk("refused", status_q[ST_MOVING], 1'b0);
    end
    motor_enable = 1'b1;
    step_clk;
    // idle, shaft on the set value, no arrows: only the in-position flag
    exp_st = 16'h8000;
    chk("st_idle", status_q, exp_st);
    // back-to-back reads: the status object, then a wrong sub-index
    rd_req = 1'b1;
    step_clk;
    rd_sub = 8'h02;
    chk("rd_ack", {rd_ack, rd_err}, 2'h2);
    chk("rd_data", rd_data, exp_st);
    step_clk;
    rd_req = 1'b0;
    rd_sub = STATUS_SUB;
    chk("rd_err", {rd_ack, rd_err}, 2'h3);
    chk("rd_err_data", rd_data, 16'h0000);
    step_clk;
    chk("rd_idle", {rd_ack, rd_err}, 2'h0);
    pdo_sync = 1'b1;
    step_clk;
    pdo_sync = 1'b0;
    chk("tpdo_strobe", tpdo_strobe, 2'h3);
    chk("tpdo_data", tpdo_data, exp_st);
    step_clk;
    chk("tpdo_once", tpdo_strobe, 2'h0);
    results;
  end
endmodule
